// ===== inc/wdt_pkg.sv
// Package: register map, field layout and timing for the board watchdog.
// Assumes a 125 MHz system clock and an 8-bit port-mapped register bus.
package wdt_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_ACTION = 12'h1D3;
    localparam logic [11:0] OFS_PIN_SETUP = 12'hC47;
    localparam logic [11:0] OFS_TIMESCALE = 12'hC65;
    localparam logic [11:0] OFS_TIMEOUT = 12'hC66;
    localparam logic [11:0] OFS_TSTATUS = 12'hC68;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'hC70;
    localparam logic [11:0] OFS_IRQ_MASK = 12'hC71;
    localparam logic [7:0] RST_ACTION = 8'h00;
    localparam logic [7:0] RST_PIN_SETUP = 8'h0E;
    localparam logic [7:0] RST_TIMESCALE = 8'h08;
    localparam logic [7:0] RST_TIMEOUT = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam int ACT_LO = 4;
    localparam int ACT_HI = 5;
    localparam int FLAG_BIT = 7;
    localparam int TS_BIT = 7;
    localparam int PIN_EN_BIT = 7;
    localparam logic [3:0] PIN_MODE_WDT = 4'hE;
    localparam int PIN_INV_BIT = 1;
    localparam int TSTAT_BIT = 0;
    localparam int IRQ_EXPIRE = 0;
    localparam int IRQ_POWERUP = 1;
    localparam int SEC_PER_MIN = 60;
    localparam int POWER_OFF_SEC = 3;
    localparam longint OFF_CYCLES = longint'(POWER_OFF_SEC) * CLK_HZ;
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_RESET = 2'b01,
        ACT_CYCLE = 2'b10,
        ACT_OFF = 2'b11
    } action_t;
endpackage

// ===== inc/wdt_timer_if.sv
// Interface: timer configuration and expiry between board logic and timer.
// Assumes one clock domain shared by both ends.
interface wdt_timer_if;
    logic load;
    logic [7:0] load_value;
    logic minutes;
    logic expired;
    modport board(output load, output load_value, output minutes,
        input expired);
    modport timer(input load, input load_value, input minutes,
        output expired);
endinterface

// ===== design/wdt_counter.sv
// Timer core: unit prescaler and 9-bit down-counter.
// Assumes a tick rate given by the clock parameter; zero load disables.
module wdt_counter
    import wdt_pkg::*;
#(
    parameter int TICKS_PER_SEC = CLK_HZ
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    wdt_timer_if.timer tif
);
    logic [31:0] sec_count;
    logic [5:0] min_count;
    logic [8:0] units_left;
    logic running;
    logic unit_tick;
    logic sec_tick;

    assign sec_tick = (sec_count == 32'(TICKS_PER_SEC - 1));
    assign unit_tick = sec_tick &&
        (!tif.minutes || min_count == 6'(SEC_PER_MIN - 1));

    // Prescaler restarts on every load
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_count <= '0;
            min_count <= '0;
        end else if (tif.load || sec_tick) begin
            sec_count <= '0;
            if (tif.load || unit_tick) begin
                min_count <= '0;
            end else begin
                min_count <= min_count + 6'h01;
            end
        end else begin
            sec_count <= sec_count + 32'h1;
        end
    end

    // Load N gives N+1 units; zero disables
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            units_left <= '0;
            running <= 1'b0;
            tif.expired <= 1'b0;
        end else if (tif.load) begin
            units_left <= {1'b0, tif.load_value} + 9'h001; // RULE7 RULE13
            running <= (tif.load_value != 8'h00); // RULE6
            tif.expired <= 1'b0;
        end else if (running && unit_tick) begin
            units_left <= units_left - 9'h001;
            if (units_left == 9'h001) begin
                running <= 1'b0;
                tif.expired <= 1'b1; // RULE13
            end
        end
    end
endmodule

// ===== design/board_watchdog_timer.sv
// Top: watchdog registers, board action sequencer and interrupt.
// Assumes a single-cycle strobe register port, data one cycle after read.
//
// Contract
// RULE1: Action field is control bits 5:4; value zero does nothing on expiry.
// RULE2: Action 10h gives a cold reset, 30h switches power off.
// RULE3: Action 20h removes power three seconds, then restores it.
// RULE4: Pin setup uses bit 7 and 3:0; 0Eh default enables watchdog output.
// RULE5: Timescale bit 7 picks seconds when set, minutes when clear.
// RULE6: Timeout register zero disables the watchdog; resets to zero.
// RULE7: Nonzero timeout N expires after N plus one units.
// RULE8: Timer status reads 00h counting, 01h after timeout.
// RULE9: Timer status survives bus reset; only software write clears it.
// RULE10: Control bit 7 reads 1 after a timeout since power-on.
// RULE11: Software rewrites timeout with nonzero value before it runs out.
// RULE12: Firmware enables the watchdog during power-on self-test.
// RULE13: Timeout writes reload; expiry pin edge launches action, sets flag.
// RULE14: Reset loads control 00h and timescale 08h; nothing armed.
module board_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int TICKS_PER_SEC = CLK_HZ,
    parameter longint POWER_OFF_CYCLES = OFF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic timer_output_pin,
    output logic cold_reset_n,
    output logic power_enable,
    output logic irq
);
    wdt_timer_if tif();

    logic [1:0] action;
    logic board_flag;
    logic [7:0] pin_setup;
    logic [7:0] timescale;
    logic [7:0] timeout;
    logic timer_flag;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic pin_seen;
    logic pin_level;
    logic expire_edge;
    logic [31:0] off_count;
    logic reset_pulse;
    logic first_cycle;
    logic [7:0] read_word;
    logic reset_go;
    logic cycle_go;
    logic off_go;
    logic restore_event;

    typedef enum logic [1:0] {
        ST_ON = 2'b00,
        ST_OFF_WAIT = 2'b01,
        ST_DEAD = 2'b10
    } power_state_t;
    power_state_t pstate;
    power_state_t next_pstate;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic strobe_hit(input logic strobe,
        input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        strobe_hit = strobe && hit(a, ofs);
    endfunction

    wdt_counter #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_counter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tif(tif.timer)
    );

    // Timeout writes reload the timer core
    assign tif.load = strobe_hit(wr_en, addr, OFS_TIMEOUT); // RULE13
    assign tif.load_value = wdata;
    assign tif.minutes = !timescale[TS_BIT]; // RULE5

    // Output pin follows the expiry level, inverted when bit 1 is set, whenever bit 7 is clear, in any mode; bit 7 set holds it high
    always_comb begin
        pin_level = tif.expired;
        if (pin_setup[PIN_INV_BIT]) begin
            pin_level = !tif.expired;
        end
        timer_output_pin = pin_setup[PIN_EN_BIT] ? 1'b1 : pin_level;
        if (pin_setup[3:0] == PIN_MODE_WDT && !pin_setup[PIN_EN_BIT]) begin
            timer_output_pin = pin_level; // RULE4
        end
    end

    // Edge on the sampled timer expiry output
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_seen <= 1'b0;
        end else begin
            pin_seen <= tif.expired;
        end
    end
    assign expire_edge = tif.expired && !pin_seen && // RULE13
        (pin_setup[3:0] == PIN_MODE_WDT);

    // Action chosen at the expiry edge
    assign reset_go = expire_edge && action == ACT_RESET; // RULE2
    assign cycle_go = expire_edge && action == ACT_CYCLE; // RULE3
    assign off_go = expire_edge && action == ACT_OFF; // RULE2

    // Action field
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            action <= RST_ACTION[ACT_HI:ACT_LO]; // RULE14
        end else if (strobe_hit(wr_en, addr, OFS_ACTION)) begin
            action <= wdata[ACT_HI:ACT_LO]; // RULE1
        end
    end

    // Output pin setup
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_setup <= RST_PIN_SETUP; // RULE4
        end else if (strobe_hit(wr_en, addr, OFS_PIN_SETUP)) begin
            pin_setup <= wdata; // RULE4
        end
    end

    // Counting unit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timescale <= RST_TIMESCALE; // RULE14
        end else if (strobe_hit(wr_en, addr, OFS_TIMESCALE)) begin
            timescale <= wdata; // RULE5
        end
    end

    // Timeout value
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout <= RST_TIMEOUT; // RULE6
        end else if (strobe_hit(wr_en, addr, OFS_TIMEOUT)) begin
            timeout <= wdata; // RULE6
        end
    end

    // Interrupt mask
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= '0;
        end else if (strobe_hit(wr_en, addr, OFS_IRQ_MASK)) begin
            irq_mask <= wdata[1:0];
        end
    end

    // Board flag: sticky until power-on reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            board_flag <= 1'b0;
        end else if (expire_edge) begin
            board_flag <= 1'b1; // RULE10
        end
    end

    // Timer flag: bus reset does not touch it; write of 1 clears, set wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_flag <= 1'b0;
        end else if (expire_edge) begin
            timer_flag <= 1'b1; // RULE8
        end else if (wr_en && hit(addr, OFS_TSTATUS) && wdata[TSTAT_BIT]) begin
            timer_flag <= 1'b0; // RULE9
        end
    end

    // Power stays off for the first cycle after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    // Interrupt status: read clears, new event wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else begin
            if (strobe_hit(rd_en, addr, OFS_IRQ_STATUS)) begin
                irq_status <= '0;
            end
            if (expire_edge) begin
                irq_status[IRQ_EXPIRE] <= 1'b1; // RULE13
            end
            if (restore_event) begin
                irq_status[IRQ_POWERUP] <= 1'b1; // RULE3
            end
        end
    end
    // Level interrupt from unmasked status bits
    assign irq = |(irq_status & irq_mask);
    assign restore_event = (pstate == ST_OFF_WAIT) && (next_pstate == ST_ON);

    // Power sequencer
    always_comb begin
        next_pstate = pstate;
        unique case (pstate)
            ST_ON: begin
                if (cycle_go) begin
                    next_pstate = ST_OFF_WAIT; // RULE3
                end else if (off_go) begin
                    next_pstate = ST_DEAD; // RULE2
                end
            end
            ST_OFF_WAIT: begin
                if (off_count == 32'(POWER_OFF_CYCLES - 1)) begin
                    next_pstate = ST_ON; // RULE3
                end
            end
            ST_DEAD: begin
                next_pstate = ST_DEAD;
            end
            default: begin
                next_pstate = ST_ON;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pstate <= ST_ON;
        end else begin
            pstate <= next_pstate;
        end
    end

    // Off time counter runs only while power is held off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_count <= '0;
        end else if (pstate == ST_OFF_WAIT) begin
            off_count <= off_count + 32'h1; // RULE3
        end else begin
            off_count <= '0;
        end
    end

    // Power enable, held off in the first cycle after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_enable <= 1'b0;
        end else begin
            power_enable <= (next_pstate == ST_ON) && !first_cycle;
        end
    end

    // Cold reset is a single-cycle low pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pulse <= 1'b0;
        end else begin
            reset_pulse <= reset_go; // RULE2
        end
    end
    assign cold_reset_n = !reset_pulse;

    // Read mux; unmapped offsets read zero
    always_comb begin
        read_word = RST_ZERO;
        unique case (addr)
            OFS_ACTION: read_word = {board_flag, 1'b0, action, 4'h0}; // RULE10
            OFS_PIN_SETUP: read_word = pin_setup;
            OFS_TIMESCALE: read_word = timescale;
            OFS_TIMEOUT: read_word = timeout;
            OFS_TSTATUS: read_word = {7'h00, timer_flag}; // RULE8
            OFS_IRQ_STATUS: read_word = {6'h00, irq_status};
            OFS_IRQ_MASK: read_word = {6'h00, irq_mask};
            default: read_word = RST_ZERO;
        endcase
    end

    // Read data, one cycle after strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= RST_ZERO;
        end else if (rd_en) begin
            rdata <= read_word;
        end else begin
            rdata <= RST_ZERO;
        end
    end

    // Bus reset leaves every flag alone
    logic unused_bus_reset;
    assign unused_bus_reset = bus_reset; // RULE9
endmodule

// ===== dv/board_watchdog_timer_asserts.sv
// Checker: port-level watchdog assertions, bound to the top module.
// Assumes pin setup keeps its 0Eh default (inverted output).
module board_watchdog_timer_asserts
    import wdt_pkg::*;
#(
    parameter longint POWER_OFF_CYCLES = OFF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic timer_output_pin,
    input wire logic cold_reset_n,
    input wire logic power_enable,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    longint low_cnt;
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Cycles with power removed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 0;
        else if (power_enable) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end
    AST_RDATA_IDLE:
        assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not idle");
    AST_RESET_PULSE:
        assert property ($fell(cold_reset_n) |=> cold_reset_n)
        else $error("cold reset pulse too long");
    AST_RESET_CAUSE:
        assert property ($fell(cold_reset_n) |-> !timer_output_pin)
        else $error("cold reset without expiry");
    AST_PWR_CAUSE:
        assert property ($fell(power_enable) |-> !timer_output_pin)
        else $error("power removed without expiry");
    AST_ONE_ACTION:
        assert property (!cold_reset_n |-> power_enable)
        else $error("reset and power action together");
    AST_ZERO_OFF:
        assert property (wr_en && addr == OFS_TIMEOUT && wdata == 8'h00
            |-> ##2 timer_output_pin [*8])
        else $error("expiry while disabled");
    AST_RELOAD:
        assert property (wr_en && addr == OFS_TIMEOUT && wdata != 8'h00
            |-> ##2 timer_output_pin [*6])
        else $error("expiry right after reload");
    AST_IRQ_CLEAR:
        assert property (rd_en && addr == OFS_IRQ_STATUS |-> ##2 !irq)
        else $error("interrupt not cleared by read");
    AST_CYCLE_LEN:
        assert property ($rose(power_enable) |-> low_cnt <= 3 ||
            (low_cnt >= POWER_OFF_CYCLES - 1 &&
            low_cnt <= POWER_OFF_CYCLES + 1))
        else $error("power off time wrong");
    AST_OFF_HOLD:
        assert property (low_cnt > POWER_OFF_CYCLES + 2 |-> !power_enable)
        else $error("power returned after power off");
endmodule

// ===== dv/board_watchdog_timer_tb.sv
// Testbench: register accesses and expiry actions at the pins.
// Assumes short unit and off counts set by parameters below.
module board_watchdog_timer_tb
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TPS = 10;
    localparam longint POFF = 30;
    logic sys_clk, rst_n, bus_reset, wr_en, rd_en;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, v;
    logic timer_output_pin, cold_reset_n, power_enable, irq;
    int miscompares = 0, compares = 0, cycles = 0;
    int first, lo_rst, lo_pwr;

    board_watchdog_timer #(.TICKS_PER_SEC(TPS), .POWER_OFF_CYCLES(POFF))
    u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_reset(bus_reset),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .timer_output_pin(timer_output_pin), .irq(irq),
        .cold_reset_n(cold_reset_n), .power_enable(power_enable));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic end_of_test;
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            $display("BAD %0t timeout", $time);
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
        chk(v, e);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    // Watch the pins for n cycles
    task automatic run(input int n);
        first = -1;
        lo_rst = 0;
        lo_pwr = 0;
        for (int i = 1; i <= n; i++) begin
            @(posedge sys_clk);
            #1;
            if (first < 0 && timer_output_pin === 1'b0) first = i;
            if (cold_reset_n === 1'b0) lo_rst++;
            if (power_enable === 1'b0) lo_pwr++;
        end
    endtask
    task automatic arm(input logic [7:0] ts, act, n, input int len);
        do_reset();
        wr(OFS_TIMESCALE, ts);
        wr(OFS_ACTION, act);
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_TIMEOUT, n);
        run(len);
    endtask
    task automatic t_reset;
        do_reset();
        rdc(OFS_ACTION, 8'h00);
        rdc(OFS_PIN_SETUP, 8'h0E);
        rdc(OFS_TIMESCALE, 8'h08);
        rdc(OFS_TIMEOUT, 8'h00);
        rdc(OFS_TSTATUS, 8'h00);
        wr(12'h000, 8'hFF);
        rdc(12'h000, 8'h00);
        wr(OFS_ACTION, 8'hFF);
        rdc(OFS_ACTION, 8'h30);
        wr(OFS_TIMESCALE, 8'h80);
        rdc(OFS_TIMESCALE, 8'h80);
        run(200);
        chk(8'(first < 0), 8'h01);
    endtask
    task automatic t_expire;
        arm(8'h80, 8'h10, 8'h02, 60);
        chk(8'(first inside {[3*TPS-3:3*TPS+3]}), 8'h01);
        chk(8'(lo_rst), 8'h01);
        chk(8'(lo_pwr), 8'h00);
        chk(8'(irq), 8'h01);
        rdc(OFS_TSTATUS, 8'h01);
        rdc(OFS_ACTION, 8'h90);
        rdc(OFS_IRQ_STATUS, 8'h01);
        chk(8'(irq), 8'h00);
        @(posedge sys_clk);
        bus_reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus_reset <= 1'b0;
        rdc(OFS_TSTATUS, 8'h01);
        wr(OFS_TSTATUS, 8'h01);
        rdc(OFS_TSTATUS, 8'h00);
        wr(OFS_TIMEOUT, 8'h00);
        run(40);
        chk(8'(first < 0), 8'h01);
        do_reset();
        rdc(OFS_ACTION, 8'h00);
    endtask
    task automatic t_feed;
        arm(8'h80, 8'h10, 8'h02, 0);
        repeat (5) begin
            run(20);
            chk(8'(first < 0), 8'h01);
            wr(OFS_TIMEOUT, 8'h02);
        end
        run(40);
        chk(8'(first inside {[3*TPS-3:3*TPS+3]}), 8'h01);
    endtask
    task automatic t_minutes;
        arm(8'h00, 8'h00, 8'h01, 1300);
        chk(8'(first inside {[120*TPS-5:120*TPS+5]}), 8'h01);
        chk(8'(lo_rst + lo_pwr), 8'h00);
        rdc(OFS_ACTION, 8'h80);
    endtask
    task automatic t_cycle;
        arm(8'h80, 8'h20, 8'h01, 100);
        chk(8'(lo_pwr inside {[POFF-1:POFF+1]}), 8'h01);
        chk(8'(power_enable), 8'h01);
        chk(8'(lo_rst), 8'h00);
        rdc(OFS_IRQ_STATUS, 8'h03);
    endtask
    task automatic t_off;
        arm(8'h80, 8'h30, 8'h01, 200);
        chk(8'(lo_pwr > 150), 8'h01);
        chk(8'(power_enable), 8'h00);
    endtask
    initial begin
        rst_n = 1'b0;
        bus_reset = 1'b0;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        t_reset();
        t_expire();
        t_feed();
        t_minutes();
        t_cycle();
        t_off();
        end_of_test();
    end
endmodule

bind board_watchdog_timer board_watchdog_timer_asserts
    #(.POWER_OFF_CYCLES(POWER_OFF_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_reset(bus_reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .timer_output_pin(timer_output_pin), .cold_reset_n(cold_reset_n),
    .power_enable(power_enable));
